// file: sem_host.sv
// Purpose: drives the token-space pins of a dual-ported part for one port
// Assumes: the part is clockless; data pins are sampled through three flops
// Notes: acquire is write zero then read back; init frees all eight flags
`default_nettype none
// Contract
// RULE1: select low, index lines pick flag
// RULE2: device uses only data bit zero
// RULE3: free flag taken reads zero here
// RULE4: owner writing one frees the flag
// RULE5: refused zero waits in request latch
// RULE6: read value fills every data bit
// RULE7: read value latched at select plus enable
// RULE8: drop select between repeated reads
// RULE9: held elsewhere: latch zero, reads one
// RULE10: request by write then read back
// RULE11: after failure, reread or write one
// RULE12: first zero latch owns until one
// RULE13: owner release hands token over
// RULE14: simultaneous requests yield one winner
// RULE15: write one to every flag at start
module sem_host #(
    parameter int STROBE_CYCLES = sem_host_pkg::STROBE_CYC,
    parameter int GAP_CYCLES = sem_host_pkg::GAP_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire sem_host_pkg::sem_cmd_t cmd,
    input wire logic cmdValid,
    output logic cmdReady,
    output logic done,
    output logic granted,
    output sem_host_pkg::sem_pins_t pins,
    output logic [sem_host_pkg::DATA_W-1:0] dataOut,
    output logic dataOutEnable,
    input wire logic [sem_host_pkg::DATA_W-1:0] dataIn
);
    import sem_host_pkg::*;

    // ----------------------------------------
    // parameter checks
    // ----------------------------------------
    // last step of each phase as the step counter sees it
    localparam int WRITE_LAST = STROBE_CYCLES - 1;
    localparam int GAP_LAST = GAP_CYCLES - 1;
    // the read strobe runs three steps longer so the word can reach the
    // last synchroniser stage while the part still drives it
    localparam int READ_LAST = STROBE_CYCLES + 2;
    // the step counter is eight bits wide
    localparam int COUNT_MAX = 255;
    if (STROBE_CYCLES < 1 || READ_LAST > COUNT_MAX) begin : gen_bad_strobe
        $error("strobe cycle count does not fit the step counter");
    end
    if (GAP_CYCLES < 1 || GAP_LAST > COUNT_MAX) begin : gen_bad_gap
        $error("gap cycle count does not fit the step counter");
    end
    // the index lines must reach every flag and no more
    if (FLAG_COUNT != 2 ** FLAG_INDEX_W) begin : gen_bad_flags
        $error("flag count does not match the index width");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_WRITE = 6'b000010,
        S_GAP = 6'b000100,
        S_READ = 6'b001000,
        S_RGAP = 6'b010000,
        S_DONE = 6'b100000
    } state_t;

    state_t state;
    sem_op_t op;
    logic [FLAG_INDEX_W-1:0] flag;
    logic writeBit;
    logic [7:0] count;
    // three stages: the part answers on its own timing, not on sys_clk
    logic [DATA_W-1:0] syncA;
    logic [DATA_W-1:0] syncB;
    logic [DATA_W-1:0] syncC;
    logic won;

    // ----------------------------------------
    // data input synchroniser
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
        end else begin
            syncA <= dataIn;
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    // whole word must agree as all zeros; a stray bit means not won [RULE6]
    assign won = (syncB == '0) && (syncC == '0);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= S_IDLE;
            op <= OP_POLL;
            flag <= '0;
            writeBit <= 1'b1;
            count <= '0;
            done <= 1'b0;
            cmdReady <= 1'b0;
        end else begin
            done <= 1'b0;
            cmdReady <= 1'b0;
            unique case (state)
                S_IDLE: begin
                    cmdReady <= 1'b1;
                    if (cmdValid && cmdReady) begin
                        cmdReady <= 1'b0;
                        op <= cmd.op;
                        flag <= cmd.op == OP_INIT ? '0 : cmd.flag;
                        count <= '0;
                        // acquire writes zero; release and init write one
                        writeBit <= cmd.op != OP_ACQUIRE; // [RULE15]
                        // poll skips the write so a failed request is reread
                        state <= cmd.op == OP_POLL ? S_READ : S_WRITE; // [RULE11]
                    end
                end
                S_WRITE: begin
                    count <= count + 8'h01;
                    if (count == 8'(WRITE_LAST)) begin
                        count <= '0;
                        state <= S_GAP;
                    end
                end
                S_GAP: begin
                    count <= count + 8'h01;
                    if (count == 8'(GAP_LAST)) begin
                        count <= '0;
                        if (op == OP_INIT) begin
                            if (flag == FLAG_INDEX_W'(FLAG_COUNT - 1)) begin
                                state <= S_DONE;
                            end else begin
                                flag <= flag + FLAG_INDEX_W'(1); // [RULE15]
                                state <= S_WRITE;
                            end
                        end else if (op == OP_RELEASE) begin
                            state <= S_DONE;
                        end else begin
                            // read only after the write, never before [RULE10]
                            state <= S_READ;
                        end
                    end
                end
                S_READ: begin
                    count <= count + 8'h01;
                    // strobe held long enough for the word to reach the
                    // last synchroniser stage before it is released
                    if (count == 8'(READ_LAST)) begin
                        count <= '0;
                        state <= S_RGAP;
                    end
                end
                S_RGAP: begin
                    // select released so the next read latches afresh [RULE8]
                    count <= count + 8'h01;
                    if (count == 8'(GAP_LAST)) begin
                        count <= '0;
                        state <= S_DONE;
                    end
                end
                S_DONE: begin
                    done <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // ownership flag
    // ----------------------------------------
    // taken at the end of the gap after the read: both compared stages
    // then hold samples from inside the strobe, never a released bus
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            granted <= 1'b0;
        end else if (state == S_RGAP && count == 8'(GAP_LAST)) begin
            granted <= won; // [RULE10]
        end else if (state == S_GAP && op == OP_RELEASE
            && count == 8'(GAP_LAST)) begin
            // a release gives the token back or withdraws a request [RULE11]
            granted <= 1'b0;
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pins <= '{1'b1, 1'b1, 1'b1, 1'b1, '0};
            dataOut <= '0;
            dataOutEnable <= 1'b0;
        end else begin
            pins.flagIndexLines <= flag; // [RULE1]
            pins.tokenSpaceSelectN <= !(state == S_WRITE
                || state == S_READ); // [RULE1]
            // memory array stays deselected: only the token space is used
            pins.chipEnableN <= 1'b1;
            pins.writeN <= !(state == S_WRITE);
            pins.readDriveEnableN <= !(state == S_READ); // [RULE7]
            // request value goes on bit zero only [RULE2]
            dataOut <= {{(DATA_W-1){1'b0}}, writeBit};
            dataOutEnable <= state == S_WRITE;
        end
    end
endmodule
`default_nettype wire

// file: sem_host_pkg.sv
// Purpose: shared constants and carriers for the token-space host controller
// Assumes: one port of a dual-ported part with eight token flags
// Notes: pin timing counts are derived from the 40 MHz system clock
`default_nettype none
package sem_host_pkg;
    localparam int CLK_MHZ = 40;
    localparam int FLAG_INDEX_W = 3;
    localparam int FLAG_COUNT = 8;
    localparam int DATA_W = 16;
    // least strobe width on the pins, in ns, rounded up to cycles
    localparam int STROBE_NS = 50;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    // least gap with select or read enable high between two accesses
    localparam int GAP_NS = 25;
    localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [DATA_W-1:0] ALL_ONES = 16'hffff;

    typedef enum logic [1:0] {
        OP_ACQUIRE = 2'h0,
        OP_RELEASE = 2'h1,
        OP_POLL = 2'h2,
        OP_INIT = 2'h3
    } sem_op_t;

    typedef struct packed {
        sem_op_t op;
        logic [FLAG_INDEX_W-1:0] flag;
    } sem_cmd_t;

    typedef struct packed {
        logic tokenSpaceSelectN;
        logic chipEnableN;
        logic writeN;
        logic readDriveEnableN;
        logic [FLAG_INDEX_W-1:0] flagIndexLines;
    } sem_pins_t;
endpackage
`default_nettype wire

// file: sem_host_asserts.sv
// Purpose: pin protocol checks for sem_host
// Assumes: ports as declared by sem_host
// Notes: bound to every sem_host instance
`default_nettype none
module sem_host_asserts (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire sem_host_pkg::sem_cmd_t cmd,
    input wire logic cmdValid,
    input wire logic cmdReady,
    input wire sem_host_pkg::sem_pins_t pins,
    input wire logic [sem_host_pkg::DATA_W-1:0] dataOut,
    input wire logic dataOutEnable
);
    timeunit 1ns;
    timeprecision 1ps;
    import sem_host_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    AST_WRITE_SELECT: assert property (dataOutEnable |->
        !pins.tokenSpaceSelectN && !pins.writeN && pins.readDriveEnableN)
        else $error("data driven outside a write");
    AST_WRITE_WIDTH: assert property ($fell(pins.writeN) |=>
        !pins.writeN ##1 pins.writeN) else $error("write strobe width");
    AST_READ_WIDTH: assert property ($fell(pins.readDriveEnableN) |->
        !pins.readDriveEnableN [*5] ##1 pins.readDriveEnableN)
        else $error("read strobe width");
    AST_READ_GAP: assert property ($rose(pins.readDriveEnableN) |->
        pins.tokenSpaceSelectN ##1 pins.readDriveEnableN)
        else $error("no gap after read");
    AST_WRITE_THEN_READ: assert property ($rose(pins.writeN) &&
        !$past(dataOut[0]) |=> !pins.readDriveEnableN)
        else $error("request not read back");
    AST_ACQ_ZERO: assert property (cmdValid && cmdReady &&
        cmd.op == OP_ACQUIRE |-> ##[1:3] dataOutEnable && !dataOut[0])
        else $error("acquire did not write zero");
    AST_REL_ONE: assert property (cmdValid && cmdReady &&
        cmd.op == OP_RELEASE |-> ##[1:3] dataOutEnable && dataOut[0])
        else $error("release did not write one");
    AST_INIT_ONE: assert property (cmdValid && cmdReady &&
        cmd.op == OP_INIT |-> ##[1:3] dataOutEnable && dataOut[0]
        && pins.flagIndexLines == 3'h0) else $error("init start wrong");
endmodule
bind sem_host sem_host_asserts u_chk (.sys_clk, .resetn, .cmd,
    .cmdValid, .cmdReady, .pins, .dataOut, .dataOutEnable);
`default_nettype wire

// file: sem_flags_model.sv
// Purpose: token flags of the part, host port and a far port
// Assumes: far port writes arrive as one-cycle pulses
// Notes: flags start held by the far port to mimic power-up junk
`default_nettype none
module sem_flags_model (
    input wire logic sys_clk,
    input wire sem_host_pkg::sem_pins_t pins,
    input wire logic [sem_host_pkg::DATA_W-1:0] dataOut,
    input wire logic oWr,
    input wire logic [2:0] oIdx,
    input wire logic oVal,
    output logic [sem_host_pkg::DATA_W-1:0] dataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    import sem_host_pkg::*;
    logic [7:0] reqH = 8'h00, reqO = 8'h00, ownH = 8'h00, ownO = 8'hff;
    logic rd = 1'b0, q = 1'b0;
    always @(posedge sys_clk) begin
        if (!pins.tokenSpaceSelectN && !pins.writeN)
            reqH[pins.flagIndexLines] = dataOut[0];
        if (oWr)
            reqO[oIdx] = oVal;
        // host wins a tie
        for (int i = 0; i < 8; i++) begin
            if (ownH[i] && reqH[i]) ownH[i] = 1'b0;
            if (ownO[i] && reqO[i]) ownO[i] = 1'b0;
            if (!ownH[i] && !ownO[i]) ownH[i] = !reqH[i];
            if (!ownH[i] && !ownO[i]) ownO[i] = !reqO[i];
        end
        // non-blocking so the host's first flop sees the bus after this edge
        if (!pins.tokenSpaceSelectN && !pins.readDriveEnableN) begin
            if (!rd) q <= !ownH[pins.flagIndexLines];
            rd <= 1'b1;
        end else rd <= 1'b0;
    end
    // released bus shows the inverse so stale data never matches
    assign dataIn = rd ? {DATA_W{q}} : {DATA_W{!q}};
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: self-checking bench for sem_host
// Assumes: far port driven by the bench through the flag model
// Notes: random flag choice from an lfsr seeded at one
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sem_host_pkg::*;
    logic sys_clk = 0, resetn = 0, cmdValid = 0, oWr = 0, oVal = 0;
    logic cmdReady, done, granted, dataOutEnable;
    sem_cmd_t cmd = '0;
    logic [2:0] oIdx = '0;
    sem_pins_t pins;
    logic [DATA_W-1:0] dataOut, dataIn;
    logic [15:0] rnd = 16'h0001;
    int bad_count = 0, n_tests = 0;
    sem_host DUT (.sys_clk, .resetn, .cmd, .cmdValid, .cmdReady, .done,
        .granted, .pins, .dataOut, .dataOutEnable, .dataIn);
    sem_flags_model partner (.sys_clk, .pins, .dataOut, .oWr, .oIdx,
        .oVal, .dataIn);
    initial forever #12.5 sys_clk = ~sys_clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string nm, input logic s, input logic e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", nm, e, s);
        end
    endtask
    task end_of_test;
        $display("%0d checks, %0d mismatches", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic run(input sem_op_t op, input logic [2:0] f);
        int i;
        for (i = 0; i < 40 && cmdReady !== 1'b1; i++) @(negedge sys_clk);
        cmd = '{op, f};
        cmdValid = 1;
        @(negedge sys_clk);
        cmdValid = 0;
        for (i = 0; i < 300 && done !== 1'b1; i++) @(negedge sys_clk);
        chk("done", done, 1'b1);
    endtask
    task automatic other(input logic [2:0] f, input logic v);
        oIdx = f;
        oVal = v;
        oWr = 1;
        @(negedge sys_clk);
        oWr = 0;
        @(negedge sys_clk);
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        resetn = 1;
        run(OP_INIT, 3'h0);
        for (int i = 0; i < 8; i++) other(i[2:0], 1'b1);
        repeat (6) begin
            rnd = lfsr(rnd);
            run(OP_ACQUIRE, rnd[2:0]);
            chk("granted", granted, 1'b1);
            run(OP_RELEASE, rnd[2:0]);
            chk("released", granted, 1'b0);
        end
        $display("init and random acquire test done");
        other(3'h5, 1'b0);
        run(OP_ACQUIRE, 3'h5);
        chk("refused", granted, 1'b0);
        run(OP_POLL, 3'h5);
        chk("poll held", granted, 1'b0);
        other(3'h5, 1'b1);
        run(OP_POLL, 3'h5);
        chk("handed over", granted, 1'b1);
        run(OP_RELEASE, 3'h5);
        other(3'h2, 1'b0);
        run(OP_ACQUIRE, 3'h2);
        run(OP_RELEASE, 3'h2);
        other(3'h2, 1'b1);
        other(3'h2, 1'b0);
        run(OP_POLL, 3'h2);
        chk("withdrawn", granted, 1'b0);
        $display("contention test done");
        end_of_test;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        end_of_test;
    end
endmodule
`default_nettype wire
